// *** core/vfc_consts.svh ***
// vfc_consts.svh: timing counts and framing constants for the flow-controlled uart
// assumes a 200 MHz system clock
`ifndef VFC_CONSTS_SVH
`define VFC_CONSTS_SVH
`define VFC_CLK_HZ        200000000
`define VFC_BAUD_DEFAULT  115200
`define VFC_BAUD_MIN      9600
`define VFC_BAUD_MAX      921600
`define VFC_DIV_DEFAULT   (`VFC_CLK_HZ / `VFC_BAUD_DEFAULT)
`define VFC_DIV_MIN       (`VFC_CLK_HZ / `VFC_BAUD_MAX)
`define VFC_DIV_MAX       (`VFC_CLK_HZ / `VFC_BAUD_MIN)
`define VFC_DIV_W         16
`define VFC_DATA_BITS     8
`define VFC_STOP_BITS     1
`define VFC_FRAME_BITS    10
`define VFC_BUF_DEPTH     2
`endif

// *** core/vfc_pkg.sv ***
// vfc_pkg.sv: types for the flow-controlled uart
// assumes vfc_consts.svh is on the include path
package vfc_pkg;
    // handshake selection
    typedef enum logic [1:0] {
        VFC_HS_NONE   = 2'b00,
        VFC_HS_OUTB   = 2'b01,
        VFC_HS_INB    = 2'b10,
        VFC_HS_BOTH   = 2'b11
    } vfc_mode_e;
    typedef enum logic [1:0] {
        VFC_TX_IDLE   = 2'b00,
        VFC_TX_SHIFT  = 2'b01
    } vfc_tx_e;
    typedef enum logic [1:0] {
        VFC_RX_IDLE   = 2'b00,
        VFC_RX_SHIFT  = 2'b01
    } vfc_rx_e;
endpackage : vfc_pkg

// *** core/vfc_uart.sv ***
// vfc_uart.sv: controller-side uart with rts/cts gating toward a target
// assumes single 200 MHz clock; target pins synchronous but passed through a synchroniser
// Function
// - drop send-permit toward target when receive buffer is full
// - with inbound gating, stop sending while receive-ready is low
// - a character already shifting out always completes
// - no-handshake mode: send-permit undriven, receive-ready ignored
// - outbound mode: drive send-permit, ignore receive-ready
// - inbound mode: send-permit undriven, send only while receive-ready high
// - combined mode: drive send-permit and gate on receive-ready
// - default 115200 baud, 8 data, 1 stop, handshake off
// - rate 9600 to 921600, each handshake line selectable
`timescale 1ns/1ps
`include "vfc_consts.svh"
module vfc_uart
    import vfc_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic [1:0]            hs_mode,
    input  wire logic [`VFC_DIV_W-1:0] baud_div,
    input  wire logic                  tgt_rx_in,
    output logic                       tgt_tx_out,
    input  wire logic                  rx_ready_in,
    output logic                       send_permit_out,
    output logic                       send_permit_oe,
    input  wire logic [7:0]            host_tx_data,
    input  wire logic                  host_tx_valid,
    output logic                       host_tx_ready,
    output logic [7:0]                 host_rx_data,
    output logic                       host_rx_valid,
    input  wire logic                  host_rx_ready,
    output logic                       tx_busy,
    output logic                       rx_frame_err
);
    // divider outside supported range replaced by the default
    logic [`VFC_DIV_W-1:0] div_eff;
    always_comb begin
        if (baud_div < `VFC_DIV_W'(`VFC_DIV_MIN) || baud_div > `VFC_DIV_W'(`VFC_DIV_MAX))
            div_eff = `VFC_DIV_W'(`VFC_DIV_DEFAULT);
        else
            div_eff = baud_div;
    end
    logic out_gate;
    logic in_gate;
    assign out_gate = hs_mode[0];
    assign in_gate  = hs_mode[1];
    // receive-ready synchroniser, first stage read only by second
    logic sy1_q, sy1_d, sy2_q, sy2_d;
    always_comb begin
        sy1_d = rx_ready_in;
        sy2_d = sy1_q;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sy1_q <= 1'b0;
            sy2_q <= 1'b0;
        end else begin
            sy1_q <= sy1_d;
            sy2_q <= sy2_d;
        end
    end
    // transmit side: host data -> target, gated between characters
    vfc_tx_e               txs_q, txs_d;
    logic [`VFC_DIV_W-1:0] txc_q, txc_d;
    logic [3:0]            txb_q, txb_d;
    logic [9:0]            txsh_q, txsh_d;
    logic                  may_send;
    assign may_send      = !in_gate || sy2_q;
    assign host_tx_ready = (txs_q == VFC_TX_IDLE) && may_send;
    always_comb begin
        txs_d  = txs_q;
        txc_d  = txc_q;
        txb_d  = txb_q;
        txsh_d = txsh_q;
        unique case (txs_q)
            VFC_TX_IDLE: begin
                if (host_tx_valid && may_send) begin // gate only between characters
                    txs_d  = VFC_TX_SHIFT;
                    txsh_d = {1'b1, host_tx_data, 1'b0}; // 8N1
                    txc_d  = div_eff - 1'b1;
                    txb_d  = 4'(`VFC_FRAME_BITS - 1);
                end
            end
            VFC_TX_SHIFT: begin
                // receive-ready not looked at here, frame runs to its stop bit
                if (txc_q != '0) begin
                    txc_d = txc_q - 1'b1;
                end else if (txb_q != 4'h0) begin
                    txc_d  = div_eff - 1'b1;
                    txb_d  = txb_q - 1'b1;
                    txsh_d = {1'b1, txsh_q[9:1]};
                end else begin
                    txs_d = VFC_TX_IDLE;
                end
            end
            default: txs_d = VFC_TX_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            txs_q  <= VFC_TX_IDLE;
            txc_q  <= '0;
            txb_q  <= 4'h0;
            txsh_q <= 10'h3ff;
        end else begin
            txs_q  <= txs_d;
            txc_q  <= txc_d;
            txb_q  <= txb_d;
            txsh_q <= txsh_d;
        end
    end
    assign tgt_tx_out = (txs_q == VFC_TX_SHIFT) ? txsh_q[0] : 1'b1;
    assign tx_busy    = (txs_q == VFC_TX_SHIFT);
    // target serial input, synchronised
    logic rs1_q, rs1_d, rs2_q, rs2_d;
    always_comb begin
        rs1_d = tgt_rx_in;
        rs2_d = rs1_q;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_q <= 1'b1;
            rs2_q <= 1'b1;
        end else begin
            rs1_q <= rs1_d;
            rs2_q <= rs2_d;
        end
    end
    // receive side: target -> buffer, sampled mid-bit
    vfc_rx_e               rxs_q, rxs_d;
    logic [`VFC_DIV_W-1:0] rxc_q, rxc_d;
    logic [3:0]            rxb_q, rxb_d;
    logic [7:0]            rxsh_q, rxsh_d;
    logic                  ferr_q, ferr_d;
    logic                  push;
    logic                  buf_ready;
    always_comb begin
        rxs_d  = rxs_q;
        rxc_d  = rxc_q;
        rxb_d  = rxb_q;
        rxsh_d = rxsh_q;
        ferr_d = ferr_q;
        push   = 1'b0;
        unique case (rxs_q)
            VFC_RX_IDLE: begin
                if (!rs2_q) begin
                    rxs_d = VFC_RX_SHIFT;
                    rxc_d = {1'b0, div_eff[`VFC_DIV_W-1:1]};
                    rxb_d = 4'h0;
                end
            end
            VFC_RX_SHIFT: begin
                if (rxc_q != '0) begin
                    rxc_d = rxc_q - 1'b1;
                end else begin
                    rxc_d = div_eff - 1'b1;
                    rxb_d = rxb_q + 1'b1;
                    if (rxb_q == 4'h0) begin
                        if (rs2_q)
                            rxs_d = VFC_RX_IDLE; // false start
                    end else if (rxb_q <= 4'(`VFC_DATA_BITS)) begin
                        rxsh_d = {rs2_q, rxsh_q[7:1]};
                    end else begin
                        rxs_d  = VFC_RX_IDLE;
                        ferr_d = !rs2_q;
                        // a word with no room is dropped; reached with send-permit undriven (no-handshake or inbound mode) or a misbehaving target
                        push   = rs2_q && buf_ready;
                    end
                end
            end
            default: rxs_d = VFC_RX_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxs_q  <= VFC_RX_IDLE;
            rxc_q  <= '0;
            rxb_q  <= 4'h0;
            rxsh_q <= 8'h00;
            ferr_q <= 1'b0;
        end else begin
            rxs_q  <= rxs_d;
            rxc_q  <= rxc_d;
            rxb_q  <= rxb_d;
            rxsh_q <= rxsh_d;
            ferr_q <= ferr_d;
        end
    end
    assign rx_frame_err = ferr_q;
    // two-entry buffer toward the host
    logic [7:0] mem_q [`VFC_BUF_DEPTH];
    logic [7:0] mem_d [`VFC_BUF_DEPTH];
    logic       wp_q, wp_d, rp_q, rp_d;
    logic [1:0] cnt_q, cnt_d;
    logic       pop;
    assign buf_ready     = (cnt_q != 2'(`VFC_BUF_DEPTH));
    assign pop           = host_rx_valid && host_rx_ready;
    assign host_rx_valid = (cnt_q != 2'd0);
    assign host_rx_data  = mem_q[rp_q];
    always_comb begin
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wp_q] = rxsh_q;
            wp_d        = ~wp_q;
        end
        if (pop)
            rp_d = ~rp_q;
        cnt_d = cnt_q + 2'(push) - 2'(pop);
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            cnt_q    <= 2'd0;
        end else begin
            mem_q <= mem_d;
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end
    // send-permit: lowered while the buffer cannot take another whole word
    logic sp_q, sp_d;
    always_comb begin
        sp_d = (cnt_q == 2'd0) || (cnt_q == 2'd1 && !(rxs_q == VFC_RX_SHIFT));
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            sp_q <= 1'b1;
        else
            sp_q <= sp_d;
    end
    assign send_permit_out = sp_q;
    assign send_permit_oe  = out_gate;
endmodule : vfc_uart

// *** sim/vfc_uart_sva.sv ***
// checker for vfc_uart port timing
// assumes it is bound onto every vfc_uart instance
`timescale 1ns/1ps
module vfc_chk (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic [1:0] hs_mode,
    input wire logic       tgt_tx_out,
    input wire logic       rx_ready_in,
    input wire logic       send_permit_out,
    input wire logic       send_permit_oe,
    input wire logic       host_tx_valid,
    input wire logic       host_tx_ready,
    input wire logic [7:0] host_rx_data,
    input wire logic       host_rx_valid,
    input wire logic       host_rx_ready,
    input wire logic       tx_busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // a taken word, then a start bit held low
    sequence s_take; host_tx_valid && host_tx_ready; endsequence
    sequence s_start; (tx_busy && !tgt_tx_out) [*8]; endsequence
    chk_take_start: assert property (s_take |=> s_start)
        else $error("no start bit after word taken");
    chk_oe_mode: assert property (send_permit_oe == hs_mode[0])
        else $error("send-permit enable disagrees with mode");
    chk_busy_ready: assert property (tx_busy |-> !host_tx_ready)
        else $error("word accepted while shifting");
    chk_in_gate: assert property ((hs_mode[1] && !rx_ready_in) [*3] |-> !host_tx_ready)
        else $error("word accepted while receive-ready low");
    chk_free_mode: assert property (!hs_mode[1] && !tx_busy |-> host_tx_ready)
        else $error("receive-ready not ignored");
    chk_idle_high: assert property (!tx_busy |-> tgt_tx_out)
        else $error("line not idle high");
    chk_permit_up: assert property (!host_rx_valid [*2] |-> send_permit_out)
        else $error("send-permit low with empty buffer");
    // a word not taken stays offered, unchanged
    sequence s_held; host_rx_valid && $stable(host_rx_data); endsequence
    chk_rx_hold: assert property (host_rx_valid && !host_rx_ready |=> s_held)
        else $error("held word lost");
endmodule : vfc_chk
bind vfc_uart vfc_chk chk (.sys_clk, .rst_n, .hs_mode, .tgt_tx_out, .rx_ready_in,
    .send_permit_out, .send_permit_oe, .host_tx_valid, .host_tx_ready, .host_rx_data,
    .host_rx_valid, .host_rx_ready, .tx_busy);

// *** sim/vfc_tgt.sv ***
// target-side partner: frames both ways and receive-ready
// assumes div tracks the bit time the controller really uses
`timescale 1ns/1ps
module vfc_tgt #(parameter int DIV = 220) (
    input  wire logic sys_clk,
    input  wire logic tgt_tx_out,
    input  wire logic send_permit_out,
    input  wire logic send_permit_oe,
    output logic      tgt_rx_in,
    output logic      rx_ready_in
);
    logic [7:0] rx_q[$];
    logic       rdy = 1'b1;
    logic       permit;
    logic [7:0] b;
    int         div = DIV;
    // undriven send-permit reads as pulled high
    assign permit = send_permit_oe ? send_permit_out : 1'b1;
    assign rx_ready_in = rdy;
    initial tgt_rx_in = 1'b1;
    // permit checked only between characters, lsb first
    task automatic send(input logic [7:0] d);
        @(posedge sys_clk);
        while (permit !== 1'b1) @(posedge sys_clk);
        for (int i = -1; i < 9; i++) begin
            tgt_rx_in <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : d[i];
            repeat (div) @(posedge sys_clk);
        end
    endtask : send
    // mid-bit sampling, always room for one more
    always begin
        @(negedge tgt_tx_out);
        repeat (div / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge sys_clk);
            b[i] = tgt_tx_out;
        end
        rx_q.push_back(b);
    end
endmodule : vfc_tgt

// *** sim/tb.sv ***
// self-checking bench for vfc_uart with target model
// assumes 200 MHz clock and a short legal bit time
`timescale 1ns/1ps
`include "vfc_consts.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    import vfc_pkg::*;
    localparam int DIV = `VFC_DIV_MIN + 3;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] hs_mode = 2'b00;
    logic [15:0] baud_div = 16'(DIV);
    logic [7:0] host_tx_data = 8'h00;
    logic host_tx_valid = 1'b0;
    logic host_rx_ready = 1'b0;
    wire logic tgt_rx_in, tgt_tx_out, rx_ready_in, send_permit_out, send_permit_oe;
    wire logic host_tx_ready, host_rx_valid, tx_busy, rx_frame_err;
    wire logic [7:0] host_rx_data;
    int errors = 0;
    int comparisons = 0;
    int cyc = 0;
    vfc_uart dut (.sys_clk, .rst_n, .hs_mode, .baud_div, .tgt_rx_in, .tgt_tx_out,
        .rx_ready_in, .send_permit_out, .send_permit_oe, .host_tx_data, .host_tx_valid,
        .host_tx_ready, .host_rx_data, .host_rx_valid, .host_rx_ready, .tx_busy, .rx_frame_err);
    vfc_tgt #(.DIV(DIV)) tgt (.sys_clk, .tgt_tx_out, .send_permit_out, .send_permit_oe,
        .tgt_rx_in, .rx_ready_in);
    always #2.5 sys_clk = ~sys_clk;
    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // hold the word until taken
    task automatic hsend(input logic [7:0] d);
        host_tx_data <= d;
        host_tx_valid <= 1'b1;
        @(posedge sys_clk);
        for (int n = 0; n < 9000 && host_tx_ready !== 1'b1; n++) @(posedge sys_clk);
        `CHK(host_tx_ready, 1'b1)
        host_tx_valid <= 1'b0;
    endtask : hsend
    task automatic tget(input logic [7:0] e);
        logic [7:0] got;
        for (int n = 0; n < 12 * tgt.div && tgt.rx_q.size() == 0; n++) @(posedge sys_clk);
        got = (tgt.rx_q.size() != 0) ? tgt.rx_q.pop_front() : 8'hxx;
        `CHK(got, e)
        repeat (2 * tgt.div) @(posedge sys_clk);
    endtask : tget
    task automatic hpop(input logic [7:0] e);
        for (int n = 0; n < 9000 && host_rx_valid !== 1'b1; n++) @(posedge sys_clk);
        `CHK(host_rx_valid, 1'b1)
        `CHK(host_rx_data, e)
        `CHK(rx_frame_err, 1'b0)
        host_rx_ready <= 1'b1;
        @(posedge sys_clk);
        host_rx_ready <= 1'b0;
        @(posedge sys_clk);
    endtask : hpop
    // every mode carries a host word out
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            hs_mode <= 2'(m);
            @(posedge sys_clk);
            hsend(8'hA5 ^ 8'(m));
            tget(8'hA5 ^ 8'(m));
        end
        $display("t_modes done");
    endtask : t_modes
    // receive-ready low blocks only in inbound gating
    task automatic t_gate();
        hs_mode <= VFC_HS_NONE;
        tgt.rdy <= 1'b0;
        repeat (4) @(posedge sys_clk);
        `CHK(host_tx_ready, 1'b1)
        hs_mode <= VFC_HS_INB;
        repeat (4) @(posedge sys_clk);
        `CHK(host_tx_ready, 1'b0)
        tgt.rdy <= 1'b1;
        hsend(8'h3C);
        tget(8'h3C);
        $display("t_gate done");
    endtask : t_gate
    // receive-ready drop mid-character
    task automatic t_drop();
        hs_mode <= VFC_HS_BOTH;
        hsend(8'h96);
        repeat (3 * DIV) @(posedge sys_clk);
        tgt.rdy <= 1'b0;
        tget(8'h96);
        tgt.rdy <= 1'b1;
        $display("t_drop done");
    endtask : t_drop
    // full buffer stalls the target
    task automatic t_full();
        hs_mode <= VFC_HS_OUTB;
        tgt.send(8'h11);
        tgt.send(8'h22);
        repeat (DIV) @(posedge sys_clk);
        `CHK(send_permit_out, 1'b0)
        fork
            tgt.send(8'h33);
        join_none
        repeat (12 * DIV) @(posedge sys_clk);
        hpop(8'h11);
        hpop(8'h22);
        hpop(8'h33);
        $display("t_full done");
    endtask : t_full
    // out-of-range divider falls back to the default rate
    task automatic t_rate();
        hs_mode <= VFC_HS_NONE;
        baud_div <= 16'h0000;
        tgt.div = `VFC_DIV_DEFAULT;
        @(posedge sys_clk);
        hsend(8'h5A);
        tget(8'h5A);
        baud_div <= 16'(DIV);
        tgt.div = DIV;
        @(posedge sys_clk);
        $display("t_rate done");
    endtask : t_rate
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_modes();
        t_gate();
        t_drop();
        t_full();
        t_rate();
        finish_test();
    end
endmodule : tb
